// ### wmp_waveform_math_processor.v
// Waveform math processor: averaging, extrema, arithmetic, functions, smoothing
`timescale 1ns/1ps
`default_nettype none
`include "wmp_defines.vh"

module wmp_waveform_math_processor #(
  parameter DBL_PRESS_CYC = `WMP_DBL_PRESS_CYC
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        derived_trace_one_enable,
  input  wire        derived_trace_two_enable,
  input  wire        engine_is_two,
  input  wire        trig_normal,
  input  wire [2:0]  mode,
  input  wire [2:0]  sub_type,
  input  wire [2:0]  avg_shift,
  input  wire [3:0]  smooth_pts,
  input  wire [2:0]  dec_log2,
  input  wire [19:0] max_sweeps,
  input  wire [2:0]  src1_sel,
  input  wire [2:0]  src2_sel,
  input  wire [9:0]  m_fact,
  input  wire [10:0] a_const,
  input  wire [15:0] gain1,
  input  wire [15:0] off1,
  input  wire [15:0] gain2,
  input  wire [15:0] off2,
  input  wire        acq_param_change,
  input  wire        reset_button,
  input  wire        trace_selected,
  input  wire        accumulation_clear_cmd,
  input  wire [2:0]  cmd_trace_id,
  input  wire [15:0] ch1_data,
  input  wire [15:0] ch2_data,
  input  wire [15:0] memc_data,
  input  wire [15:0] memd_data,
  input  wire [15:0] trace_one_data,
  input  wire        smp_valid,
  input  wire        smp_last,
  output wire        smp_ready,
  output wire        out_valid,
  input  wire        out_ready,
  output wire [15:0] out_data,
  output wire [19:0] sweep_count,
  output wire        env_error,
  output wire        busy
);

  localparam ST_CAP    = 2'h0;
  localparam ST_SMOOTH = 2'h1;
  localparam ST_EMIT   = 2'h2;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Divide by one hundred through a reciprocal multiply, no divider needed
  function signed [31:0] scale_hund;
    input signed [47:0] v;
    reg   signed [47:0] m;
    begin
      m = (v * `WMP_RECIP_HUND) >>> `WMP_RECIP_SH;
      scale_hund = m[31:0];
    end
  endfunction

  // Sample to common physical units, gain in Q8
  function signed [31:0] to_phys;
    input signed [31:0] v;
    input signed [15:0] off;
    input        [15:0] gain;
    reg   signed [47:0] m;
    begin
      m = ((v - off) * $signed({1'b0, gain})) >>> `WMP_FRAC;
      to_phys = m[31:0];
    end
  endfunction

  function [15:0] sat16;
    input signed [47:0] v;
    begin
      if (v > $signed(48'sh7FFF)) begin
        sat16 = `WMP_SMAX16;
      end else if (v < -$signed(48'sh8000)) begin
        sat16 = `WMP_SMIN16;
      end else begin
        sat16 = v[15:0];
      end
    end
  endfunction

  function [15:0] isqrt;
    input [31:0] v;
    reg   [31:0] r;
    reg   [31:0] b;
    reg   [31:0] rem;
    integer      k;
    begin
      rem = v;
      r   = 32'h0;
      b   = 32'h40000000;
      for (k = 0; k < 16; k = k + 1) begin
        if (rem >= r + b) begin
          rem = rem - r - b;
          r   = (r >> 1) + b;
        end else begin
          r = r >> 1;
        end
        b = b >> 2;
      end
      isqrt = r[15:0];
    end
  endfunction

  // source choice
  // Illegal selections fall back to channel one
  function [15:0] pick_src;
    input [2:0]  sel;
    input        acc_only;
    input [79:0] d;
    begin
      case (sel)
        `WMP_SRC_CH1:  pick_src = d[15:0];
        `WMP_SRC_CH2:  pick_src = d[31:16];
        `WMP_SRC_MEMC: pick_src = acc_only ? d[15:0] : d[47:32];
        `WMP_SRC_MEMD: pick_src = acc_only ? d[15:0] : d[63:48];
        `WMP_SRC_DT1:  pick_src = engine_is_two ? d[79:64] : d[15:0];
        default:       pick_src = d[15:0];
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0]               state_ff;
  reg [`WMP_IDX_W-1:0]    idx_ff;
  reg [`WMP_IDX_W-1:0]    sidx_ff;
  reg [2:0]               pass_ff;
  reg [`WMP_ACC_W-1:0]    mem_ff [0:`WMP_RECLEN-1];
  reg [`WMP_ACC_W-1:0]    sprev_ff;
  reg [`WMP_CNT_W-1:0]    sweep_count_ff;
  reg signed [31:0]       integ_ff;
  reg signed [31:0]       prev_ff;
  reg [`WMP_CFG_W-1:0]    cfg_ff;
  reg [31:0]              press_win_ff;
  reg                     env_error_ff;
  reg                     busy_ff;

  wire trace_on  = engine_is_two ? derived_trace_two_enable : derived_trace_one_enable;
  wire acc_mode  = (mode == `WMP_MODE_AVG) || (mode == `WMP_MODE_EXTR);
  wire is_smooth = (mode == `WMP_MODE_SMOOTH);
  wire fifo_ready;
  wire [79:0] src_bus = {trace_one_data, memd_data, memc_data, ch2_data, ch1_data};

  wire stopped = (mode == `WMP_MODE_EXTR) && (sweep_count_ff >= max_sweeps);
  // gate, averaging has no limit term
  wire run = trace_on && (!acc_mode || (trig_normal && !stopped));
  assign smp_ready = (state_ff == ST_CAP) && fifo_ready;
  wire fire = smp_valid && smp_ready;
  wire proc = fire && run;

  wire [2:0]            dec  = (dec_log2 > `WMP_DEC_MAX) ? `WMP_DEC_MAX : dec_log2;
  wire [`WMP_IDX_W-1:0] mask = `WMP_IDX_MAX >> (`WMP_DEC_MAX - dec);
  wire [`WMP_IDX_W-1:0] last_red = `WMP_IDX_MAX >> dec;
  wire one_pt = (smooth_pts == 4'h1);
  wire [`WMP_IDX_W-1:0] emit_last = one_pt ? `WMP_IDX_MAX : last_red;
  wire [2:0] shift_n = (avg_shift == 3'h0) ? 3'h1 : avg_shift;

  // sweep limit is left out so raising it does not clear
  wire [`WMP_CFG_W-1:0] cfg_now = {mode, sub_type, avg_shift, smooth_pts, dec_log2,
                                   src1_sel, src2_sel, m_fact, a_const};
  wire cfg_chg = (cfg_now != cfg_ff);

  // double press inside the window on the selected trace
  wire dbl_press = reset_button && trace_selected && (press_win_ff != 32'h0);
  wire cmd_is_one = (cmd_trace_id == `WMP_TRACE_ONE);
  wire cmd_is_two = (cmd_trace_id == `WMP_TRACE_TWO);
  wire cmd_on  = (cmd_is_one && derived_trace_one_enable) ||
                 (cmd_is_two && derived_trace_two_enable);
  wire cmd_mine = engine_is_two ? cmd_is_two : cmd_is_one;
  wire cmd_hit = accumulation_clear_cmd && cmd_on && cmd_mine;
  wire clr = acq_param_change || dbl_press || cmd_hit || cfg_chg;

  // ----------------------------------------------------------------
  // Per-sample datapath
  // ----------------------------------------------------------------
  reg signed [15:0] x1;
  reg signed [15:0] x2;
  reg signed [47:0] t48;
  reg signed [31:0] s1;
  reg signed [31:0] p1;
  reg signed [31:0] p2;
  reg signed [31:0] acc_rd;
  reg signed [31:0] acc_new;
  reg signed [31:0] xq;
  reg [15:0]        str_val;

  always @* begin
    x1 = $signed(pick_src(src1_sel, acc_mode, src_bus));
    x2 = $signed(pick_src(src2_sel, 1'b0, src_bus));
    // scale then add constant in divisions of source one
    t48 = x1 * $signed({1'b0, m_fact});
    s1  = scale_hund(t48) + scale_hund($signed(a_const) * `WMP_LSB_PER_DIV);
    // both sources brought to common units first
    p1  = to_phys(s1, $signed(off1), gain1);
    p2  = to_phys({{16{x2[15]}}, x2}, $signed(off2), gain2);
    acc_rd = {{8{mem_ff[idx_ff][`WMP_ACC_W-1]}}, mem_ff[idx_ff]};
    xq     = {{8{x1[15]}}, x1, 8'h00};
    acc_new = xq;
    t48     = 48'sh0;
    case (mode)
      `WMP_MODE_AVG: begin
        if (sweep_count_ff != 20'h0) begin
          acc_new = acc_rd + ((xq - acc_rd) >>> shift_n);
        end
        t48 = acc_new >>> `WMP_FRAC;
      end
      `WMP_MODE_EXTR: begin
        // roof keeps larger, floor keeps smaller
        if (sweep_count_ff != 20'h0) begin
          if (sub_type == `WMP_EXT_FLOOR) begin
            acc_new = (xq < acc_rd) ? xq : acc_rd;
          end else begin
            acc_new = (xq > acc_rd) ? xq : acc_rd;
          end
        end
        t48 = acc_new >>> `WMP_FRAC;
      end
      `WMP_MODE_ARITH: begin
        case (sub_type)
          `WMP_ARI_SUM: t48 = p1 + p2;
          `WMP_ARI_DIF: t48 = p1 - p2;
          `WMP_ARI_PRD: t48 = (p1 * p2) >>> `WMP_FRAC;
          `WMP_ARI_RIO: t48 = (p2 == 32'sh0) ? ((p1 < 0) ? -48'sh8000 : 48'sh7FFF)
                                             : (p1 * 48'sh100) / p2;
          default:      t48 = p1 + p2;
        endcase
      end
      `WMP_MODE_FUNC: begin
        case (sub_type)
          `WMP_FNC_NEG:   t48 = -s1;
          `WMP_FNC_SQRT:  t48 = (s1 < 0) ? 48'sh0 : {32'h0, isqrt(s1)};
          `WMP_FNC_INTEG: t48 = (idx_ff == 6'h0) ? s1 : integ_ff + s1;
          `WMP_FNC_DIFF:  t48 = (idx_ff == 6'h0) ? 48'sh0 : s1 - prev_ff;
          default:        t48 = -s1;
        endcase
      end
      default: t48 = 48'sh0;
    endcase
    str_val = sat16(t48);
  end

  // ----------------------------------------------------------------
  // Smoothing pass and emit datapath
  // ----------------------------------------------------------------
  reg signed [31:0]    cur;
  reg signed [31:0]    nxt;
  reg signed [31:0]    prv;
  reg signed [31:0]    ysm;
  reg signed [31:0]    m0;
  reg signed [31:0]    m1;
  reg signed [47:0]    itp;
  reg [`WMP_IDX_W-1:0] bin;
  reg [`WMP_IDX_W-1:0] frac;
  reg [15:0]           emit_val;

  always @* begin
    cur = {{8{mem_ff[sidx_ff][`WMP_ACC_W-1]}}, mem_ff[sidx_ff]};
    nxt = (sidx_ff == last_red) ? cur :
          {{8{mem_ff[sidx_ff+1'b1][`WMP_ACC_W-1]}}, mem_ff[sidx_ff+1'b1]};
    prv = (sidx_ff == 6'h0) ? cur : {{8{sprev_ff[`WMP_ACC_W-1]}}, sprev_ff};
    ysm = (prv + (cur <<< 1) + nxt) >>> 2;
    // bin means joined by straight lines
    bin  = sidx_ff >> dec;
    frac = sidx_ff & mask;
    m0 = $signed({{8{mem_ff[bin][`WMP_ACC_W-1]}}, mem_ff[bin]}) >>> dec;
    m1 = (bin == last_red) ? m0 :
         $signed({{8{mem_ff[bin+1'b1][`WMP_ACC_W-1]}}, mem_ff[bin+1'b1]}) >>> dec;
    itp = m0 + (((m1 - m0) * $signed({1'b0, frac})) >>> dec);
    if (one_pt) begin
      emit_val = sat16(itp);
    end else begin
      emit_val = sat16(cur >>> `WMP_FRAC);
    end
  end

  wire        emit_push = (state_ff == ST_EMIT);
  wire        fifo_in_v = emit_push || (proc && !is_smooth);
  wire [15:0] fifo_in_d = emit_push ? emit_val : str_val;

  // ----------------------------------------------------------------
  // Control and storage
  // ----------------------------------------------------------------
  // Memory reset loops cost area, but a cleared record reads defined
  integer j;
  always @(posedge clk) begin
    if (!nrst) begin
      state_ff       <= ST_CAP;
      idx_ff         <= 6'h0;
      sidx_ff        <= 6'h0;
      pass_ff        <= 3'h0;
      sprev_ff       <= 24'h0;
      sweep_count_ff <= 20'h0;
      integ_ff       <= 32'sh0;
      prev_ff        <= 32'sh0;
      cfg_ff         <= {`WMP_CFG_W{1'b0}};
      press_win_ff   <= 32'h0;
      env_error_ff   <= 1'b0;
      busy_ff        <= 1'b0;
      for (j = 0; j < `WMP_RECLEN; j = j + 1) begin
        mem_ff[j] <= 24'h0;
      end
    end else begin
      cfg_ff  <= cfg_now;
      busy_ff <= (state_ff != ST_CAP);
      // error on off or non-derived target
      env_error_ff <= accumulation_clear_cmd && !cmd_on;
      if (reset_button && trace_selected) begin
        press_win_ff <= dbl_press ? 32'h0 : DBL_PRESS_CYC;
      end else if (press_win_ff != 32'h0) begin
        press_win_ff <= press_win_ff - 32'h1;
      end
      if (fire) begin
        idx_ff <= smp_last ? 6'h0 : idx_ff + 1'b1;
      end
      if (clr) begin
        sweep_count_ff <= 20'h0;
      end else if (proc && smp_last && acc_mode && sweep_count_ff != `WMP_CNT_MAX) begin
        sweep_count_ff <= sweep_count_ff + 20'h1;
      end
      case (state_ff)
        ST_CAP: begin
          if (proc) begin
            integ_ff <= t48[31:0];
            prev_ff  <= s1;
            if (acc_mode) begin
              mem_ff[idx_ff] <= acc_new[`WMP_ACC_W-1:0];
            end else if (is_smooth && one_pt) begin
              mem_ff[idx_ff >> dec] <= ((idx_ff & mask) == 6'h0) ? xq[31:8] :
                                       mem_ff[idx_ff >> dec] + xq[31:8];
            end else if (is_smooth && ((idx_ff & mask) == 6'h0)) begin
              mem_ff[idx_ff >> dec] <= xq[`WMP_ACC_W-1:0];
            end
            if (smp_last && is_smooth) begin
              sidx_ff <= 6'h0;
              pass_ff  <= smooth_pts[3:1];
              state_ff <= one_pt ? ST_EMIT : ST_SMOOTH;
            end
          end
        end
        ST_SMOOTH: begin
          // repeated passes give the binomial kernels
          mem_ff[sidx_ff] <= ysm[`WMP_ACC_W-1:0];
          sprev_ff        <= cur[`WMP_ACC_W-1:0];
          if (sidx_ff == last_red) begin
            sidx_ff <= 6'h0;
            pass_ff <= pass_ff - 3'h1;
            if (pass_ff == 3'h1) begin
              state_ff <= ST_EMIT;
            end
          end else begin
            sidx_ff <= sidx_ff + 1'b1;
          end
        end
        ST_EMIT: begin
          if (fifo_ready) begin
            if (sidx_ff == emit_last) begin
              sidx_ff  <= 6'h0;
              state_ff <= ST_CAP;
            end else begin
              sidx_ff <= sidx_ff + 1'b1;
            end
          end
        end
        default: state_ff <= ST_CAP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------
  wmp_fifo #(
    .W     (`WMP_SMP_W),
    .DEPTH (`WMP_FIFO_DEPTH),
    .AW    (`WMP_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (fifo_in_v),
    .in_ready  (fifo_ready),
    .in_data   (fifo_in_d),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  assign sweep_count = sweep_count_ff;
  assign env_error   = env_error_ff;
  assign busy        = busy_ff;

endmodule

`default_nettype wire

// ### wmp_defines.vh
// Shared constants of the waveform math processor
`ifndef WMP_DEFINES_VH
`define WMP_DEFINES_VH

// ----------------------------------------------------------------
// Widths and record geometry
// ----------------------------------------------------------------
`define WMP_SMP_W        16
`define WMP_ACC_W        24
`define WMP_FRAC         8
`define WMP_RECLEN       64
`define WMP_IDX_W        6
`define WMP_IDX_MAX      6'h3F
`define WMP_DEC_MAX      3'h6
`define WMP_CNT_W        20
`define WMP_CNT_MAX      20'hFFFFF
`define WMP_CFG_W        43
`define WMP_FIFO_DEPTH   32
`define WMP_FIFO_AW      5

// ----------------------------------------------------------------
// Processing modes and sub types
// ----------------------------------------------------------------
`define WMP_MODE_AVG     3'h0
`define WMP_MODE_EXTR    3'h1
`define WMP_MODE_ARITH   3'h2
`define WMP_MODE_FUNC    3'h3
`define WMP_MODE_SMOOTH  3'h4
`define WMP_EXT_ROOF     3'h0
`define WMP_EXT_FLOOR    3'h1
`define WMP_ARI_SUM      3'h0
`define WMP_ARI_DIF      3'h1
`define WMP_ARI_PRD      3'h2
`define WMP_ARI_RIO      3'h3
`define WMP_FNC_NEG      3'h0
`define WMP_FNC_SQRT     3'h1
`define WMP_FNC_INTEG    3'h2
`define WMP_FNC_DIFF     3'h3

// ----------------------------------------------------------------
// Source selection and trace identities
// ----------------------------------------------------------------
`define WMP_SRC_CH1      3'h0
`define WMP_SRC_CH2      3'h1
`define WMP_SRC_MEMC     3'h2
`define WMP_SRC_MEMD     3'h3
`define WMP_SRC_DT1      3'h4
`define WMP_TRACE_ONE    3'h4
`define WMP_TRACE_TWO    3'h5

// ----------------------------------------------------------------
// Scaling and timing
// ----------------------------------------------------------------
`define WMP_RECIP_HUND   48'sh51F
`define WMP_RECIP_SH     17
`define WMP_LSB_PER_DIV  48'sh20
`define WMP_SMIN16       16'h8000
`define WMP_SMAX16       16'h7FFF
`define WMP_CLK_KHZ      200000
`define WMP_DBL_PRESS_MS 500
`define WMP_DBL_PRESS_CYC (`WMP_DBL_PRESS_MS * `WMP_CLK_KHZ)

`endif

// ### wmp_fifo.v
// Output FIFO of the waveform math processor
`timescale 1ns/1ps
`default_nettype none

module wmp_fifo #(
  parameter W     = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire         clk,
  input  wire         nrst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0]  mem_ff [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_ff;
  reg [AW-1:0] rd_ptr_ff;
  reg [AW:0]   count_ff;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  // Full and empty come from the level, so back-pressure is exact
  assign in_ready  = (count_ff != DEPTH[AW:0]);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];

  // Pointer and level update
  always @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Storage needs no reset, entries are only read once written
  always @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule

`default_nettype wire

// ### wmp_assertions.sv
// Port-level checks of the waveform math processor
`timescale 1ns/1ps
`default_nettype none
module wmp_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        engine_is_two,
  input wire logic        derived_trace_one_enable,
  input wire logic        trig_normal,
  input wire logic [2:0]  mode,
  input wire logic [19:0] max_sweeps,
  input wire logic        acq_param_change,
  input wire logic        accumulation_clear_cmd,
  input wire logic [2:0]  cmd_trace_id,
  input wire logic        smp_valid,
  input wire logic        smp_last,
  input wire logic        smp_ready,
  input wire logic        out_valid,
  input wire logic [19:0] sweep_count,
  input wire logic        env_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Sweep events
  // ----------------------------------------
  // Clears by parameter change or command are excluded since they win over the count
  sequence sweep_end_s;
    smp_valid && smp_ready && smp_last && !acq_param_change && !accumulation_clear_cmd;
  endsequence
  sequence run_avg_s;
    mode == 3'h0 && $stable(mode) && trig_normal && derived_trace_one_enable;
  endsequence
  sequence take_s;
    smp_valid && smp_ready && !engine_is_two && !out_valid;
  endsequence
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  avg_free_a:
    assert property (sweep_end_s ##0 run_avg_s ##0 sweep_count != 20'hFFFFF
      |=> sweep_count == $past(sweep_count) + 20'h1) else $error("average count stuck");
  pause_hold_a:
    assert property (sweep_end_s ##0 (!trig_normal && mode == 3'h0)
      |=> $stable(sweep_count)) else $error("count moved in single mode");
  ext_stop_a:
    assert property (sweep_end_s ##0 (mode == 3'h1 && $stable(mode) && $stable(max_sweeps)
      && sweep_count >= max_sweeps) |=> $stable(sweep_count)) else $error("extrema ran on");
  off_idle_a:
    assert property (take_s ##0 (!derived_trace_one_enable && mode < 3'h4)
      |=> !out_valid) else $error("output from disabled trace");
  stream_out_a:
    assert property (take_s ##0 (derived_trace_one_enable && (mode == 3'h2 || mode == 3'h3))
      |=> out_valid) else $error("no streamed result");
  acq_clear_a:
    assert property (acq_param_change |=> sweep_count == 20'h0) else $error("no clear");
  cmd_clear_a:
    assert property (accumulation_clear_cmd && cmd_trace_id == 3'h4 && !engine_is_two
      && derived_trace_one_enable |=> sweep_count == 20'h0) else $error("command ignored");
  bad_id_a:
    assert property (accumulation_clear_cmd && cmd_trace_id != 3'h4 && cmd_trace_id != 3'h5
      |=> env_error) else $error("bad trace id accepted");
  off_err_a:
    assert property (accumulation_clear_cmd && cmd_trace_id == 3'h4
      && !derived_trace_one_enable |=> env_error) else $error("clear of off trace accepted");
  spur_err_a:
    assert property (!accumulation_clear_cmd |=> !env_error) else $error("spurious error");
endmodule
`default_nettype wire

// ### wmp_src_model.sv
// Acquisition memory model that streams 64-sample sweeps
`timescale 1ns/1ps
`default_nettype none
module wmp_src_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        go,
  input  wire logic        gap,
  input  wire logic [15:0] base1,
  input  wire logic [15:0] base2,
  input  wire logic [15:0] step,
  input  wire logic        smp_ready,
  output logic             smp_valid,
  output logic             smp_last,
  output logic [15:0]      ch1_data,
  output logic [15:0]      ch2_data,
  output logic             src_busy
);
  logic [5:0] idx_ff;
  // both channels share one index and timebase
  assign ch1_data = smp_valid ? base1 + step * idx_ff : ~(base1 + step * idx_ff);
  assign ch2_data = smp_valid ? base2 + step * idx_ff : ~(base2 + step * idx_ff);
  assign smp_last = smp_valid && idx_ff == 6'h3F;
  // Request held until taken; gap makes the source slow at random
  always @(posedge clk) begin
    if (!nrst) begin
      smp_valid <= 1'b0;
      src_busy <= 1'b0;
      idx_ff <= 6'h0;
    end else if (go && !src_busy) begin
      src_busy <= 1'b1;
      idx_ff <= 6'h0;
      smp_valid <= !gap;
    end else if (smp_valid && smp_ready) begin
      idx_ff <= idx_ff + 6'h1;
      src_busy <= !smp_last;
      smp_valid <= !smp_last && !gap;
    end else if (src_busy && !smp_valid) begin
      smp_valid <= !gap;
    end
  end
endmodule
`default_nettype wire

// ### wmp_waveform_math_processor_tb_top.sv
// Self-checking bench of the waveform math processor
`timescale 1ns/1ps
`default_nettype none
module wmp_waveform_math_processor_tb_top;
  logic clk = 1'b0, nrst = 1'b0, go = 1'b0, gap = 1'b0, hold = 1'b0, out_ready = 1'b1;
  logic derived_trace_one_enable = 1'b1, derived_trace_two_enable = 1'b0;
  logic trig_normal = 1'b1, acq_param_change = 1'b0, accumulation_clear_cmd = 1'b0;
  logic [2:0] mode = 3'h0, sub_type = 3'h0, avg_shift = 3'h2, dec_log2 = 3'h0;
  logic [2:0] src1_sel = 3'h0, src2_sel = 3'h1, cmd_trace_id = 3'h4;
  logic [3:0] smooth_pts = 4'h3;
  logic [19:0] max_sweeps = 20'h1;
  logic [9:0] m_fact = 10'h64;
  logic [10:0] a_const = 11'h0;
  logic [15:0] gain1 = 16'h100, off1 = 16'h0, gain2 = 16'h200, off2 = 16'h32;
  logic [15:0] base1 = 16'h0, base2 = 16'h64, step = 16'h0;
  logic reset_button = 1'b0, trace_selected = 1'b1;
  // Tied off: second engine and reference memories
  wire engine_is_two = 1'b0;
  wire [15:0] memc_data = 16'h0, memd_data = 16'h0;
  wire smp_ready, out_valid, env_error, busy, smp_valid, smp_last, src_busy;
  wire [15:0] out_data, ch1_data, ch2_data, trace_one_data;
  wire [19:0] sweep_count;
  int seed = 61234, err_count = 0, compares = 0, acc = 0;
  int ae[4] = '{400, 200, 117, 768};
  int fs[3] = '{0, 1, 3};
  int fe[3] = '{-632, 25, 0};
  logic [15:0] exq[$];
  wmp_waveform_math_processor #(.DBL_PRESS_CYC(20)) DUT (.*);
  wmp_src_model src (.*);
  assign trace_one_data = ch2_data;
  always #2.5 clk = ~clk;
  // Random stalls on both sides; hold lets the output buffer fill
  always @(posedge clk) begin
    gap <= ($random(seed) & 3) == 0;
    out_ready <= !hold && ($random(seed) & 1);
  end
  // Oldest expected value against each output taken
  always @(posedge clk) begin
    if (out_valid && out_ready) begin
      if (exq.size() == 0) chk_val(out_data, 16'hX);
      else chk_val(out_data, exq.pop_front());
    end
  end
  task chk_val(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: data %0h not %0h", $time, got, exp);
    end
  endtask
  task chk_cnt(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: count %0h not %0h", $time, got, exp);
    end
  endtask
  function int ema(input int x, input int first);
    acc = first ? x * 256 : acc + ((x * 256 - acc) >>> 2);
    return acc >>> 8;
  endfunction
  task fill(input int e);
    repeat (64) exq.push_back(e[15:0]);
  endtask
  // One sweep, then wait until source, design and queue are idle
  task sw(input int x, input int st, input int n);
    repeat (3) @(posedge clk);
    base1 <= x[15:0];
    step <= st[15:0];
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (3000) begin
      @(negedge clk);
      if (!src_busy && !go && !out_valid && !busy && exq.size() == 0) break;
    end
    chk_cnt(exq.size() + src_busy + busy + out_valid, 0);
    if (n >= 0) chk_cnt(sweep_count, n);
  endtask
  task op(input int s, input int e);
    @(posedge clk) sub_type <= s[2:0];
    fill(e);
    sw(300, 0, -1);
  endtask
  task cmd(input logic [2:0] id, input logic e);
    // remote clear pulse for one cycle
    @(posedge clk) begin
      accumulation_clear_cmd <= 1'b1;
      cmd_trace_id <= id;
    end
    @(posedge clk) accumulation_clear_cmd <= 1'b0;
    @(negedge clk) chk_cnt({19'h0, env_error}, {19'h0, e});
  endtask
  // Binomial result by repeated three-point passes, edges replicated
  task smooth(input int p, input int d);
    int w[64];
    int y[64];
    int n;
    n = 64 >> d;
    @(posedge clk) begin
      smooth_pts <= p[3:0];
      dec_log2 <= d[2:0];
    end
    for (int i = 0; i < n; i++) w[i] = (64 + 16 * (i << d)) * 256;
    repeat (p / 2) begin
      for (int i = 0; i < n; i++) y[i] = (w[i > 0 ? i - 1 : 0] + 2 * w[i] + w[i < n - 1 ? i + 1 : i]) >>> 2;
      w = y;
    end
    for (int i = 0; i < (p == 1 ? 64 : n); i++)
      exq.push_back(p == 1 ? 72 + 16 * (i < 62 ? i : 62) : w[i] >>> 8);
    sw(64, 16, -1);
  endtask
  task final_report;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    fill(ema(400, 1)); sw(400, 0, 1);
    fill(ema(0, 0)); sw(0, 0, 2);
    fill(ema(800, 0)); sw(800, 0, 3);
    @(posedge clk) trig_normal <= 1'b0;
    sw(1000, 0, 3);
    @(posedge clk) begin trig_normal <= 1'b1; derived_trace_one_enable <= 1'b0; end
    sw(1000, 0, 3);
    @(posedge clk) derived_trace_one_enable <= 1'b1;
    fill(ema(0, 0)); sw(0, 0, 4);
    @(posedge clk) reset_button <= 1'b1;
    repeat (2) @(posedge clk);
    reset_button <= 1'b0;
    @(negedge clk) chk_cnt(sweep_count, 0);
    fill(ema(600, 1)); sw(600, 0, 1);
    @(posedge clk) begin mode <= 3'h1; max_sweeps <= 20'h2; end
    fill(100); sw(100, 0, 1);
    fill(100); sw(50, 0, 2);
    sw(500, 0, 2);
    @(posedge clk) max_sweeps <= 20'h3;
    fill(500); sw(500, 0, 3);
    @(posedge clk) sub_type <= 3'h1;
    fill(100); sw(100, 0, 1);
    fill(50); sw(50, 0, 2);
    cmd(3'h4, 1'b0); chk_cnt(sweep_count, 0);
    cmd(3'h6, 1'b1); cmd(3'h5, 1'b1);
    @(posedge clk) derived_trace_one_enable <= 1'b0;
    cmd(3'h4, 1'b1);
    @(posedge clk) derived_trace_one_enable <= 1'b1;
    fill(70); sw(70, 0, 1);
    @(posedge clk) acq_param_change <= 1'b1;
    @(posedge clk) acq_param_change <= 1'b0;
    @(negedge clk) chk_cnt(sweep_count, 0);
    // Output held back until the buffer refuses samples
    @(posedge clk) begin mode <= 3'h2; hold <= 1'b1; end
    fork
      op(0, ae[0]);
      begin
        repeat (300) begin @(negedge clk); if (!smp_ready) break; end
        chk_cnt({19'h0, smp_ready}, 20'h0);
        @(posedge clk) hold <= 1'b0;
      end
    join
    for (int i = 1; i < 4; i++) op(i, ae[i]);
    @(posedge clk) begin mode <= 3'h3; m_fact <= 10'hC8; a_const <= 11'h64; end
    for (int i = 0; i < 3; i++) op(fs[i], fe[i]);
    @(posedge clk) mode <= 3'h4;
    for (int p = 3; p < 10; p += 2) smooth(p, 0);
    smooth(3, 1);
    smooth(1, 1);
    chk_cnt(exq.size(), 0);
    final_report;
  end
  // Run normally ends well inside this span
  initial begin
    #400000;
    err_count++;
    final_report;
  end
endmodule
bind wmp_waveform_math_processor wmp_assertions u_chk (.*);
`default_nettype wire
